/* File: verilog/ivs_pkg.sv */
// package: constants and carriers for the interrupt vector selection block
package ivs_pkg;
  localparam int IVS_ADDR_W = 24;
  localparam int IVS_TRAP_N = 8;
  localparam int IVS_IRQ_N = 16;
  localparam int IVS_PRIO_W = 3;
  localparam int IVS_IDX_W = 7;
  localparam logic [IVS_ADDR_W-1:0] IVS_PRIMARY_BASE = 24'h000004;
  localparam logic [IVS_ADDR_W-1:0] IVS_ALT_OFFSET = 24'h000100;
  localparam logic [IVS_ADDR_W-1:0] IVS_RESET_PC = 24'h000000;
  localparam logic [IVS_IDX_W-1:0] IVS_TRAP_SLOTS = 7'h08;
  localparam int IVS_NVM_VECTOR = 15;
  localparam int IVS_NVM_PRIO_LSB = 12;
  localparam logic [2:0] IVS_TRAP_OSC = 3'h1;
  localparam logic [2:0] IVS_TRAP_ADDR = 3'h2;
  localparam logic [2:0] IVS_TRAP_STACK = 3'h3;
  localparam logic [2:0] IVS_TRAP_MATH = 3'h4;

  typedef enum logic [1:0] {
    IVS_IDLE  = 2'b00,
    IVS_FETCH = 2'b01,
    IVS_LOAD  = 2'b10
  } ivs_state_t;

  typedef struct packed {
    logic osc_fail;
    logic addr_err;
    logic stack_err;
    logic math_err;
  } ivs_traps_t;

  typedef struct packed {
    logic valid;
    logic is_trap;
    logic [IVS_IDX_W-1:0] index;
    logic [IVS_PRIO_W:0] level;
  } ivs_pick_t;
endpackage

/* File: verilog/ivs_arbiter.sv */
// module: picks the winning trap or interrupt request
module ivs_arbiter #(
  parameter int N_IRQ = ivs_pkg::IVS_IRQ_N
) (
  input wire ivs_pkg::ivs_traps_t traps_in,            // trap request levels
  input wire logic [N_IRQ-1:0] pending_in,             // pending flags
  input wire logic [N_IRQ-1:0] enable_in,              // source enables
  input wire logic [N_IRQ*ivs_pkg::IVS_PRIO_W-1:0] prio_in, // 3-bit priorities
  output ivs_pkg::ivs_pick_t pick_out                  // winning request
);
  import ivs_pkg::*;

  logic [IVS_TRAP_N-1:0] trap_vec;

  always_comb begin
    trap_vec = '0;
    trap_vec[IVS_TRAP_OSC] = traps_in.osc_fail;
    trap_vec[IVS_TRAP_ADDR] = traps_in.addr_err;
    trap_vec[IVS_TRAP_STACK] = traps_in.stack_err;
    trap_vec[IVS_TRAP_MATH] = traps_in.math_err;
    pick_out = '0;
    // highest user priority wins; >= lets the lower vector, visited last, take a tie
    for (int i = N_IRQ - 1; i >= 0; i--) begin
      if (pending_in[i] && enable_in[i] && prio_in[i*IVS_PRIO_W +: IVS_PRIO_W] != '0) begin
        if (!pick_out.valid ||
            {1'b0, prio_in[i*IVS_PRIO_W +: IVS_PRIO_W]} >= pick_out.level) begin // [RULE_12]
          pick_out.valid = 1'b1;
          pick_out.is_trap = 1'b0;
          pick_out.index = IVS_IDX_W'(i);
          pick_out.level = {1'b0, prio_in[i*IVS_PRIO_W +: IVS_PRIO_W]};
        end
      end
    end
    // traps outrank all user levels; lower trap number first
    for (int t = IVS_TRAP_N - 1; t >= 0; t--) begin
      if (trap_vec[t]) begin
        pick_out.valid = 1'b1;
        pick_out.is_trap = 1'b1;
        pick_out.index = IVS_IDX_W'(t);
        pick_out.level = {1'b1, IVS_PRIO_W'(t)};
      end
    end
  end
endmodule

/* File: verilog/ivs_top.sv */
// module: vector address generation and vector fetch toward the cpu core
// Function
// RULE_01: select bit chooses alternate or primary table
// RULE_02: alternate vector equals primary plus 0x100
// RULE_03: reset takes no vector fetch
// RULE_04: reset clears state, program counter zero
// RULE_05: eight trap vectors at 0x04 to 0x12
// RULE_06: interrupt N at 0x14 plus twice N
// RULE_07: write-complete interrupt is vector 15, 0x32
// RULE_08: firmware fills unused slots with reset handler
// RULE_09: firmware mirrors primary into unused alternate table
// RULE_10: firmware puts jump at reset address
// RULE_11: vector entry is 24-bit handler address
// RULE_12: equal priority favours lower vector address
// RULE_13: fetch address is base plus twice index
module ivs_top #(
  parameter int N_IRQ = ivs_pkg::IVS_IRQ_N
) (
  input wire logic clk_in,                              // system clock, 25 MHz
  input wire logic rst_n_in,                            // async device reset, low
  input wire logic alternate_table_select_in,           // interrupt_control_two bit 15
  input wire ivs_pkg::ivs_traps_t traps_in,             // trap requests
  input wire logic [N_IRQ-1:0] pending_flags_first_in,  // pending flags
  input wire logic [N_IRQ-1:0] source_enables_first_in, // source enables
  input wire logic [N_IRQ*ivs_pkg::IVS_PRIO_W-1:0] priority_fields_in, // priorities
  input wire logic [ivs_pkg::IVS_PRIO_W:0] cpu_level_in, // current cpu level
  input wire logic fetch_ready_in,                      // cpu: fetch data valid
  input wire logic [ivs_pkg::IVS_ADDR_W-1:0] fetch_data_in, // vector entry word
  output logic fetch_req_out,                           // vector fetch request
  output logic [ivs_pkg::IVS_ADDR_W-1:0] fetch_addr_out, // vector fetch address
  output logic pc_load_out,                             // load pc pulse
  output logic [ivs_pkg::IVS_ADDR_W-1:0] pc_out,        // program counter value
  output logic [ivs_pkg::IVS_IDX_W-1:0] vector_num_out, // taken vector number
  output logic [ivs_pkg::IVS_PRIO_W:0] new_level_out,   // taken level
  output logic nvm_irq_pending_out                      // write-complete enabled+pending
);
  import ivs_pkg::*;

  ivs_pick_t pick;
  ivs_state_t state_q, state_d;
  logic [IVS_ADDR_W-1:0] addr_q, addr_d;
  logic [IVS_ADDR_W-1:0] pc_q, pc_d;
  logic [IVS_IDX_W-1:0] num_q, num_d;
  logic [IVS_PRIO_W:0] lvl_q, lvl_d;
  logic load_q, load_d;
  logic [IVS_IDX_W-1:0] slot;
  logic [IVS_ADDR_W-1:0] base;

  // ---------------------------------------------------------------
  // request selection
  // ---------------------------------------------------------------
  ivs_arbiter #(.N_IRQ(N_IRQ)) u_arb (
    .traps_in(traps_in),
    .pending_in(pending_flags_first_in),
    .enable_in(source_enables_first_in),
    .prio_in(priority_fields_in),
    .pick_out(pick)
  );

  // write-complete source: flag/enable bit 15, priority 14:12 of fourth field word
  assign nvm_irq_pending_out = pending_flags_first_in[IVS_NVM_VECTOR] &&
                               source_enables_first_in[IVS_NVM_VECTOR]; // [RULE_07]

  // ---------------------------------------------------------------
  // vector address
  // ---------------------------------------------------------------
  always_comb begin
    // traps take slots 0..7, interrupts follow from slot 8
    slot = pick.is_trap ? pick.index : pick.index + IVS_TRAP_SLOTS; // [RULE_05] [RULE_06]
    base = alternate_table_select_in ? IVS_PRIMARY_BASE + IVS_ALT_OFFSET
                                     : IVS_PRIMARY_BASE; // [RULE_01] [RULE_02]
  end

  // ---------------------------------------------------------------
  // fetch sequence
  // ---------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    addr_d = addr_q;
    pc_d = pc_q;
    num_d = num_q;
    lvl_d = lvl_q;
    load_d = 1'b0;
    unique case (state_q)
      IVS_IDLE: begin
        if (pick.valid && pick.level > cpu_level_in) begin
          addr_d = base + (IVS_ADDR_W'(slot) << 1); // [RULE_13]
          num_d = pick.index;
          lvl_d = pick.level;
          state_d = IVS_FETCH;
        end
      end
      IVS_FETCH: begin
        if (fetch_ready_in) begin
          pc_d = fetch_data_in; // [RULE_11]
          load_d = 1'b1;
          state_d = IVS_LOAD;
        end
      end
      IVS_LOAD: begin
        state_d = IVS_IDLE;
      end
    endcase
  end

  // reset clears everything; pc starts at zero, no vector is fetched
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_q <= IVS_IDLE; // [RULE_03]
      addr_q <= '0;
      pc_q <= IVS_RESET_PC; // [RULE_04]
      num_q <= '0;
      lvl_q <= '0;
      load_q <= 1'b0;
    end else begin
      state_q <= state_d;
      addr_q <= addr_d;
      pc_q <= pc_d;
      num_q <= num_d;
      lvl_q <= lvl_d;
      load_q <= load_d;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign fetch_req_out = (state_q == IVS_FETCH);
  assign fetch_addr_out = addr_q;
  assign pc_load_out = load_q;
  assign pc_out = pc_q;
  assign vector_num_out = num_q;
  assign new_level_out = lvl_q;
endmodule

/* File: verif/ivs_top_asserts.sv */
// checker: port-level properties of the vector selection block
module ivs_top_asserts
  import ivs_pkg::*;
#(parameter int N_IRQ = IVS_IRQ_N) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic alternate_table_select_in,
  input wire logic [N_IRQ-1:0] pending_flags_first_in,
  input wire logic [N_IRQ-1:0] source_enables_first_in,
  input wire logic fetch_ready_in,
  input wire logic [IVS_ADDR_W-1:0] fetch_data_in,
  input wire logic fetch_req_out,
  input wire logic [IVS_ADDR_W-1:0] fetch_addr_out,
  input wire logic pc_load_out,
  input wire logic [IVS_ADDR_W-1:0] pc_out,
  input wire logic [IVS_IDX_W-1:0] vector_num_out,
  input wire logic [IVS_PRIO_W:0] new_level_out,
  input wire logic nvm_irq_pending_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  sequence wait_s; fetch_req_out && !fetch_ready_in; endsequence
  sequence done_s; fetch_req_out && fetch_ready_in; endsequence
  req_hold_a: assert property (wait_s |=> fetch_req_out && $stable(fetch_addr_out))
    else $error("fetch request dropped or moved");
  pc_load_a: assert property (done_s |=> pc_load_out && pc_out == $past(fetch_data_in))
    else $error("handler address not loaded");
  load_pulse_a: assert property (pc_load_out |=> !pc_load_out && !fetch_req_out)
    else $error("load pulse too long");
  table_sel_a: assert property ($rose(fetch_req_out) |->
    fetch_addr_out[23:8] == {15'h0000, $past(alternate_table_select_in)}) else $error("wrong table");
  slot_addr_a: assert property (fetch_req_out |-> fetch_addr_out[7:0] ==
    8'(4 + 2 * (vector_num_out + (new_level_out[3] ? 0 : 8)))) else $error("wrong slot");
  reset_quiet_a: assert property (!$past(rst_n_in) |-> !fetch_req_out && pc_out == 24'h000000)
    else $error("activity right after reset");
  nvm_flag_a: assert property (nvm_irq_pending_out ==
    (pending_flags_first_in[15] & source_enables_first_in[15])) else $error("write-complete flag");
  trap_level_a: assert property (fetch_req_out && new_level_out[3] |->
    vector_num_out < 7'h08 && new_level_out[2:0] == vector_num_out[2:0]) else $error("trap level");
endmodule
bind ivs_top ivs_top_asserts #(.N_IRQ(N_IRQ)) u_chk (.clk_in, .rst_n_in, .alternate_table_select_in,
  .pending_flags_first_in, .source_enables_first_in, .fetch_ready_in, .fetch_data_in, .fetch_req_out,
  .fetch_addr_out, .pc_load_out, .pc_out, .vector_num_out, .new_level_out, .nvm_irq_pending_out);

/* File: verif/ivs_cpu_model.sv */
// model: cpu core answering vector fetches with the fetch address xor 0x5A0000
module ivs_cpu_model
  import ivs_pkg::*;
(
  input wire logic clk_in,                          // system clock
  input wire logic fetch_req_out,                   // fetch request
  input wire logic [IVS_ADDR_W-1:0] fetch_addr_out, // vector address
  input wire logic [1:0] slow_in,                   // wait cycles before answer
  output logic fetch_ready_in = 1'b0,               // answer strobe
  output logic [IVS_ADDR_W-1:0] fetch_data_in = '0  // entry word
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] wait_q = 2'h0;
  always @(posedge clk_in) begin
    if (fetch_req_out && !fetch_ready_in && wait_q == slow_in) begin
      fetch_ready_in <= 1'b1;
      fetch_data_in <= fetch_addr_out ^ 24'h5A0000;
      wait_q <= 2'h0;
    end else begin
      fetch_ready_in <= 1'b0;
      fetch_data_in <= ~fetch_data_in;
      wait_q <= (fetch_req_out && !fetch_ready_in) ? wait_q + 2'h1 : 2'h0;
    end
  end
endmodule

/* File: verif/test_interrupt_vector_selection.sv */
// testbench: vector fetch scenarios for the vector selection block
module test_interrupt_vector_selection
  import ivs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_in = 1'b0, rst_n_in = 1'b0, alternate_table_select_in = 1'b0;
  ivs_traps_t traps_in = '0;
  logic [15:0] pending_flags_first_in = '0, source_enables_first_in = 16'hFFFF;
  logic [47:0] priority_fields_in = '0;
  logic [3:0] cpu_level_in = 4'h0, new_level_out;
  logic [1:0] slow = 2'h0;
  logic fetch_ready_in, fetch_req_out, pc_load_out, nvm_irq_pending_out;
  logic [23:0] fetch_data_in, fetch_addr_out, pc_out;
  logic [6:0] vector_num_out;
  int err_total = 0, comparisons = 0;
  initial forever #20 clk_in = ~clk_in;
  ivs_top dut (.clk_in, .rst_n_in, .alternate_table_select_in, .traps_in, .pending_flags_first_in,
    .source_enables_first_in, .priority_fields_in, .cpu_level_in, .fetch_ready_in, .fetch_data_in,
    .fetch_req_out, .fetch_addr_out, .pc_load_out, .pc_out, .vector_num_out, .new_level_out,
    .nvm_irq_pending_out);
  ivs_cpu_model cpu (.clk_in, .fetch_req_out, .fetch_addr_out, .slow_in(slow), .fetch_ready_in,
    .fetch_data_in);
  task automatic check(logic [23:0] seen, logic [23:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // raises one request set, follows the fetch and checks the loaded handler
  task automatic run(logic alt, logic [3:0] trp, logic [15:0] pnd, logic [47:0] pri, logic [6:0] num);
    logic [23:0] exp;
    exp = (alt ? 24'h000104 : 24'h000004) + 24'(2 * (num + (trp != 4'h0 ? 0 : 8)));
    @(posedge clk_in);
    alternate_table_select_in <= alt;
    traps_in <= trp;
    pending_flags_first_in <= pnd;
    priority_fields_in <= pri;
    slow <= {alt, 1'b0};
    for (int i = 0; i < 20 && pc_load_out !== 1'b1; i++) begin
      @(negedge clk_in);
      if (fetch_req_out === 1'b1) check(fetch_addr_out, exp);
    end
    if (pc_load_out !== 1'b1) begin
      err_total++;
      close_out();
    end
    check(pc_out, exp ^ 24'h5A0000);
    check(24'(vector_num_out), 24'(num));
    check(24'(new_level_out), 24'(trp != 4'h0 ? {1'b1, num[2:0]} : {1'b0, pri[3*num +: 3]}));
    @(posedge clk_in);
    traps_in <= '0;
    pending_flags_first_in <= '0;
    repeat (3) @(posedge clk_in);
    $display("test done vector %0d", num);
  endtask
  // requests that must be ignored: level not above the cpu, or source disabled
  task automatic refuse(logic [3:0] lvl, logic [15:0] en);
    @(posedge clk_in);
    cpu_level_in <= lvl;
    source_enables_first_in <= en;
    pending_flags_first_in <= 16'h8020;
    priority_fields_in <= (48'h7 << 45) | (48'h4 << 15);
    repeat (8) begin
      @(negedge clk_in);
      check(24'(fetch_req_out), 24'h000000);
    end
    check(24'(nvm_irq_pending_out), 24'(en[15]));
    @(posedge clk_in);
    cpu_level_in <= 4'h0;
    source_enables_first_in <= 16'hFFFF;
    pending_flags_first_in <= '0;
    $display("test done refusal");
  endtask
  initial begin
    repeat (3) @(posedge clk_in);
    rst_n_in <= 1'b1;
    @(negedge clk_in);
    check(pc_out, 24'h000000);
    check(24'(fetch_req_out), 24'h000000);
    for (int t = 1; t <= 4; t++) run(t[0], 4'h1 << (4 - t), '0, '0, 7'(t));
    run(1'b0, 4'h6, 16'h8000, 48'h1 << 45, 7'h02);
    run(1'b0, 4'h0, 16'h8000, 48'h1 << 45, 7'h0F);
    run(1'b1, 4'h0, 16'h8001, (48'h3 << 45) | 48'h3, 7'h00);
    run(1'b0, 4'h0, 16'h2001, (48'h2 << 39) | 48'h1, 7'h0D);
    refuse(4'h7, 16'hFFFF);
    refuse(4'h0, 16'h0000);
    close_out();
  end
endmodule
